// >>> hdl/scrk_keeper.sv
// segmented capture buffer with reserved regions of interest
// Behaviour
// R01: capture writes samples segment by segment through the buffer cyclically.
// R02: a segment reached by a region is reserved until software releases it.
// R03: a region is a start sample and a length in samples.
// R04: regions pass idle, pending, busy, complete and deleted states; a one-sample region goes from pending straight to complete.
// R05: segments hold 6MB and a finished region holds at least one segment.
// R06: capture needs at least eight unreserved segments to run.
// R07: when free segments run short capture halts with an error.
// R08: the buffer is 384MB, 64 segments, about 50 held regions.
// R09: software loads all regions for a shot before it starts.
// R10: software supplies regions sorted by start sample.
// R11: software keeps regions disjoint.
// R12: software keeps the programme modest and frees regions promptly.
// R13: each newly finished region is signalled at once.
// R14: a sample counter against start and start plus length drives states.
`timescale 1ns/10ps
`default_nettype none
module scrk_keeper
  import scrk_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // shot control
  input  wire logic              arm,
  input  wire logic              stop,
  // region loading
  input  wire logic              load_we,
  input  wire logic [REG_W-1:0]  load_idx,
  input  wire logic [SAMP_W-1:0] load_start,
  input  wire logic [LEN_W-1:0]  load_len,
  input  wire logic [REG_W:0]    load_count,
  // region release
  input  wire logic              release_we,
  input  wire logic [REG_W-1:0]  release_idx,
  // sample stream in
  input  wire logic              samp_valid,
  input  wire logic [DATA_W-1:0] samp_data,
  output logic                   samp_ready,
  // memory write stream out
  output logic                   mem_valid,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      mem_data,
  input  wire logic              mem_ready,
  // status
  output logic                   running,
  output logic                   error,
  output logic                   done_pulse,
  output logic [REG_W-1:0]       done_idx,
  output logic [SEG_W:0]         free_segs
);
  typedef enum logic [1:0] {CS_STOP, CS_RUN, CS_ERR} scrk_cap_e;

  localparam logic [OFS_W-1:0] LAST_OFS = OFS_W'(SEG_WORDS - 1);
  localparam logic [SEG_W:0]   MIN_FREE = (SEG_W+1)'(MIN_FREE_SEG);
  localparam logic [SEG_W:0]   ALL_SEG  = (SEG_W+1)'(NUM_SEG);

  scrk_cap_e                 cap;
  logic [SAMP_W-1:0]         r_start [NUM_REG];
  logic [LEN_W-1:0]          r_len   [NUM_REG];
  scrk_rstate_e              r_st    [NUM_REG];
  logic [NUM_SEG-1:0]        r_hold  [NUM_REG];
  logic [NUM_SEG-1:0]        held;
  logic [REG_W:0]            nreg;
  logic [REG_W:0]            cur;
  logic [SAMP_W-1:0]         samp_cnt;
  logic [SEG_W-1:0]          seg;
  logic [OFS_W-1:0]          ofs;
  logic                      take;
  logic                      seg_end;
  logic [SEG_W-1:0]          next_seg;
  logic                      buf_in_valid;
  logic                      buf_in_ready;
  logic                      buf_out_valid;
  logic [ADDR_W+DATA_W-1:0]  buf_out;
  logic [SEG_W:0]            free_now;

  // reserved segment map from all held regions
  always_comb
  begin
    held = '0;
    for (int i = 0; i < NUM_REG; i++)
      held = held | r_hold[i];
  end

  always_comb
  begin
    free_now = '0;
    for (int s = 0; s < NUM_SEG; s++)
      free_now = free_now + (SEG_W+1)'(!held[s]);
  end

  // next free segment after the current one
  always_comb
  begin
    next_seg = seg;
    for (int k = NUM_SEG - 1; k >= 1; k--)
      if (!held[SEG_W'(seg + SEG_W'(k))])
        next_seg = SEG_W'(seg + SEG_W'(k));
  end

  assign samp_ready   = (cap == CS_RUN) && buf_in_ready;
  assign take         = samp_valid && samp_ready;
  assign seg_end      = (ofs == LAST_OFS);
  assign buf_in_valid = samp_valid && (cap == CS_RUN);

  // capture state
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      cap <= CS_STOP;
    else
      case (cap)
        CS_STOP:
          if (arm)
            cap <= CS_RUN;
        CS_RUN:
          // R07: halt on starvation
          if (free_now < MIN_FREE)
            cap <= CS_ERR;
          else if (stop)
            cap <= CS_STOP;
        CS_ERR:
          if (arm)
            cap <= CS_STOP;
        default:
          cap <= CS_STOP;
      endcase
  end

  // R01: cyclic segment fill, skipping held segments
  always_ff @(posedge ref_clk)
  begin
    if (reset || (cap == CS_STOP && arm))
    begin
      seg      <= reset ? '0 : (held[seg] ? next_seg : seg);
      ofs      <= '0;
      samp_cnt <= '0;
    end
    else if (take)
    begin
      samp_cnt <= samp_cnt + SAMP_W'(1);
      if (seg_end)
      begin
        ofs <= '0;
        seg <= next_seg;
      end
      else
        ofs <= ofs + OFS_W'(1);
    end
  end

  // region table, states and reservations
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      nreg       <= '0;
      cur        <= '0;
      done_pulse <= 1'b0;
      done_idx   <= '0;
      for (int i = 0; i < NUM_REG; i++)
      begin
        r_st[i]   <= RS_IDLE;
        r_hold[i] <= '0;
      end
    end
    else
    begin
      done_pulse <= 1'b0;
      // R03: region start and length
      if (load_we && cap != CS_RUN)
      begin
        r_start[load_idx] <= load_start;
        r_len[load_idx]   <= load_len;
        r_st[load_idx]    <= RS_IDLE;
        r_hold[load_idx]  <= '0;
      end
      if (cap == CS_STOP && arm)
      begin
        // R04: arming moves regions to pending
        nreg <= load_count;
        cur  <= '0;
        for (int i = 0; i < NUM_REG; i++)
          if (r_st[i] == RS_IDLE && (REG_W+1)'(i) < load_count)
            r_st[i] <= RS_PENDING;
      end
      else if (take && cur < nreg)
      begin
        // R14: start compare enters busy
        if (r_st[cur[REG_W-1:0]] == RS_PENDING &&
            samp_cnt == r_start[cur[REG_W-1:0]])
          r_st[cur[REG_W-1:0]] <= RS_BUSY;
        // R02: reserve segment under region
        if (r_st[cur[REG_W-1:0]] == RS_BUSY ||
            samp_cnt == r_start[cur[REG_W-1:0]])
          r_hold[cur[REG_W-1:0]][seg] <= 1'b1;
        // R14: end compare marks complete
        if (samp_cnt + SAMP_W'(1) ==
            r_start[cur[REG_W-1:0]] + SAMP_W'(r_len[cur[REG_W-1:0]]))
        begin
          r_st[cur[REG_W-1:0]] <= RS_COMPLETE;
          cur                  <= cur + (REG_W+1)'(1);
          // R13: signal finished region
          done_pulse <= 1'b1;
          done_idx   <= cur[REG_W-1:0];
        end
      end
      // R05: release returns whole segments
      if (release_we && r_st[release_idx] == RS_COMPLETE)
      begin
        r_st[release_idx]   <= RS_DELETED;
        r_hold[release_idx] <= '0;
      end
    end
  end

  // R06: free segment count as status
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      free_segs <= ALL_SEG;
      running   <= 1'b0;
      error     <= 1'b0;
    end
    else
    begin
      free_segs <= free_now;
      running   <= (cap == CS_RUN);
      error     <= (cap == CS_ERR);
    end
  end

  scrk_skid #(
    .W (ADDR_W + DATA_W)
  ) u_buf (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (buf_in_valid),
    .in_data   ({seg, ofs, samp_data}),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out),
    .out_ready (!mem_valid || mem_ready)
  );

  // registered memory write port
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mem_valid <= 1'b0;
      mem_addr  <= '0;
      mem_data  <= '0;
    end
    else if (!mem_valid || mem_ready)
    begin
      mem_valid <= buf_out_valid;
      mem_addr  <= buf_out[ADDR_W+DATA_W-1:DATA_W];
      mem_data  <= buf_out[DATA_W-1:0];
    end
  end

  // R02: never start writing a segment that is already held
  no_held_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    take && ofs == '0 |-> !held[seg]) // R02
    else $error("write into held segment");
  // R07: starvation leads to error
  starve_err_a: assert property (@(posedge ref_clk) disable iff (reset)
    cap == CS_RUN && free_now < MIN_FREE |-> ##2 error) // R07
    else $error("no error after starvation");
  // R13: completion flagged once
  done_once_a: assert property (@(posedge ref_clk) disable iff (reset)
    done_pulse |=> !done_pulse || $changed(done_idx)) // R13
    else $error("completion pulse repeated");
  // R01: offset steps by one before segment end
  seg_step_a: assert property (@(posedge ref_clk) disable iff (reset)
    take && !seg_end |=> ofs == $past(ofs) + OFS_W'(1)) // R01
    else $error("offset did not step");
  // R06: running implies enough free
  run_free_a: assert property (@(posedge ref_clk) disable iff (reset)
    running && $past(running) |-> $past(free_segs) >= MIN_FREE ||
    !$past(running, 2)) // R06
    else $error("running while starved");
  // R04: stopped state takes no samples
  stop_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    cap != CS_RUN && !arm |=> $stable(samp_cnt)) // R04
    else $error("sample taken while stopped");
  // R05: finished region holds a segment
  held_min_a: assert property (@(posedge ref_clk) disable iff (reset)
    done_pulse |-> r_hold[done_idx] != '0) // R05
    else $error("finished region holds no segment");
  // R08: output held steady under stall
  out_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr)) // R08
    else $error("write dropped under stall");
endmodule
`default_nettype wire

// >>> hdl/scrk_pkg.sv
// constants for the segmented capture region keeper
package scrk_pkg;
  // buffer geometry
  localparam int unsigned SEG_MBYTES   = 6;
  localparam int unsigned BUF_MBYTES   = 384;
  localparam int unsigned NUM_SEG      = BUF_MBYTES / SEG_MBYTES;
  localparam int unsigned SEG_W        = 6;
  localparam int unsigned MIN_FREE_SEG = 8;
  localparam int unsigned TYP_MAX_HELD = 50;
  // sample word and segment depth in words
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned SEG_WORDS    = SEG_MBYTES * 1048576 / (DATA_W / 8);
  localparam int unsigned OFS_W        = 21;
  localparam int unsigned ADDR_W       = SEG_W + OFS_W;
  // region list
  localparam int unsigned NUM_REG      = 64;
  localparam int unsigned REG_W        = 6;
  localparam int unsigned SAMP_W       = 48;
  localparam int unsigned LEN_W        = 32;
  // region states
  typedef enum logic [2:0]
  {
    RS_IDLE     = 3'h0,
    RS_PENDING  = 3'h1,
    RS_BUSY     = 3'h2,
    RS_COMPLETE = 3'h3,
    RS_DELETED  = 3'h4
  } scrk_rstate_e;
endpackage

// >>> hdl/scrk_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module scrk_skid
  import scrk_pkg::*;
#(
  parameter int unsigned W = 32
)
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic [W-1:0] mem [2];
  logic         rd_ptr;
  logic         wr_ptr;
  logic [1:0]   count;
  logic         push;
  logic         pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = out_valid ? mem[rd_ptr] : '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  no_overflow_a: assert property (@(posedge ref_clk) disable iff (reset)
    count <= 2'h2) else $error("buffer count above two");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the segmented capture region keeper
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import scrk_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic              ref_clk = 1'b0;
  logic              reset = 1'b1;
  logic              arm = 1'b0;
  logic              stop = 1'b0;
  logic              load_we = 1'b0;
  logic [REG_W-1:0]  load_idx = '0;
  logic [SAMP_W-1:0] load_start = '0;
  logic [LEN_W-1:0]  load_len = '0;
  logic [REG_W:0]    load_count = '0;
  logic              release_we = 1'b0;
  logic [REG_W-1:0]  release_idx = '0;
  logic              samp_valid = 1'b0;
  logic [DATA_W-1:0] samp_data = '0;
  logic              samp_ready;
  logic              mem_valid;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_data;
  logic              mem_ready = 1'b0;
  logic              running;
  logic              error;
  logic              done_pulse;
  logic [REG_W-1:0]  done_idx;
  logic [SEG_W:0]    free_segs;
  int                fails = 0;
  int                check_count = 0;
  int                taken = 0;
  int                out_n = 0;
  int                held_n = 0;
  int                done_n = 0;
  logic [31:0]       lfsr_q = 32'h0000_0701;
  logic [DATA_W-1:0] exp_q[$];
  int                rs[3] = '{10, 15, 40};
  int                rl[3] = '{5, 1, 20};

  always #2.5 ref_clk = ~ref_clk;

  scrk_keeper u_scrk_keeper (
    .ref_clk(ref_clk), .reset(reset), .arm(arm), .stop(stop),
    .load_we(load_we), .load_idx(load_idx), .load_start(load_start),
    .load_len(load_len), .load_count(load_count),
    .release_we(release_we), .release_idx(release_idx),
    .samp_valid(samp_valid), .samp_data(samp_data),
    .samp_ready(samp_ready), .mem_valid(mem_valid),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_ready(mem_ready),
    .running(running), .error(error), .done_pulse(done_pulse),
    .done_idx(done_idx), .free_segs(free_segs)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1]
              ^ lfsr_q[0]};
    return lfsr_q;
  endfunction

  function automatic logic in_window(input int i, input int n);
    return n >= rs[i] + rl[i] && n <= rs[i] + rl[i] + 2;
  endfunction

  task automatic compare(input string nm, input logic [47:0] exp,
                         input logic [47:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse_load(input int i);
    load_we = 1'b1;
    load_idx = REG_W'(i);
    load_start = SAMP_W'(rs[i]);
    load_len = LEN_W'(rl[i]);
    tick(1);
    load_we = 1'b0;
    tick(1);
  endtask

  task automatic pulse_release(input int i);
    release_we = 1'b1;
    release_idx = REG_W'(i);
    tick(1);
    release_we = 1'b0;
    tick(2);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // monitor
  // ------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (samp_valid && samp_ready)
    begin
      exp_q.push_back(samp_data);
      taken++;
    end
    if (mem_valid && mem_ready)
    begin
      if (exp_q.size() > 0)
        compare("mem_data", 48'(exp_q.pop_front()), 48'(mem_data));
      compare("mem_addr", 48'(out_n), 48'(mem_addr));
      out_n++;
    end
    if (done_pulse === 1'b1)
    begin
      compare("done_idx", 48'(done_n), 48'(done_idx));
      if (done_n < 3)
        compare("done_time", 48'h1, 48'(in_window(done_n, taken)));
      done_n++;
    end
  end

  initial
  begin
    #100000;
    fails++;
    complete_run();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    tick(6);
    reset = 1'b0;
    tick(1);
    compare("running", 48'h0, 48'(running));
    compare("error", 48'h0, 48'(error));
    compare("mem_valid", 48'h0, 48'(mem_valid));
    compare("free_segs", 48'(NUM_SEG), 48'(free_segs));
    $display("test reset done");
    for (int i = 0; i < 3; i++)
      pulse_load(i);
    load_count = 7'h03;
    arm = 1'b1;
    tick(1);
    arm = 1'b0;
    tick(1);
    compare("running", 48'h1, 48'(running));
    while (taken < 70)
    begin
      // hold an offered word until taken
      if (!samp_valid || taken != held_n)
      begin
        samp_valid = rnd() % 4 != 0;
        samp_data = rnd();
      end
      held_n = taken;
      mem_ready = rnd() % 3 != 0;
      tick(1);
    end
    samp_valid = 1'b0;
    mem_ready = 1'b1;
    tick(20);
    compare("words_out", 48'd70, 48'(out_n));
    compare("done_count", 48'd3, 48'(done_n));
    compare("error", 48'h0, 48'(error));
    $display("test stream done");
    // held segment stays out of the free count
    compare("free_segs", 48'(NUM_SEG - 1), 48'(free_segs));
    pulse_release(7);
    compare("free_segs", 48'(NUM_SEG - 1), 48'(free_segs));
    for (int i = 0; i < 3; i++)
      pulse_release(i);
    compare("free_segs", 48'(NUM_SEG), 48'(free_segs));
    $display("test release done");
    stop = 1'b1;
    tick(1);
    stop = 1'b0;
    tick(2);
    compare("running", 48'h0, 48'(running));
    samp_valid = 1'b1;
    tick(1);
    compare("samp_ready", 48'h0, 48'(samp_ready));
    samp_valid = 1'b0;
    $display("test stop done");
    complete_run();
  end
endmodule
`default_nettype wire
